//--- hdl/mie_core.sv
// Instruction execute unit: decode, register file, pointer and watchdog.
`timescale 1ns/1ns
module mie_core #(
	parameter int PRESCALE_W = 7 // Watchdog prescaler width
) (
	input wire logic i_sys_clk, // 250 MHz clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_ce, // Clock enable, freezes all state when low
	input wire logic [13:0] i_instr, // Instruction word at the pointer
	input wire logic [4:0] i_pointer_high_latch, // Page latch value
	input wire logic [6:0] i_peek_addr, // Register file read address
	output logic o_instr_take, // Instruction consumed this clock
	output logic [7:0] o_peek_data, // Register file read data
	output logic [12:0] o_instruction_pointer, // Current pointer
	output logic [12:0] o_stack_head, // Last pushed return address
	output logic [7:0] o_accum, // Accumulator
	output logic o_carry, // Carry flag
	output logic o_nibble_overflow_flag, // Digit carry flag
	output logic o_zero, // Zero flag
	output logic o_expiry_flag, // Time-out status flag
	output logic o_sleep_entered_flag, // Power-down status flag
	output logic [7:0] o_watchdog_counter, // Watchdog count
	output logic o_flush // Current cycle runs as an idle slot
);
	mie_pkg::mie_phase_t phase_reg;
	logic [7:0] file_mem [128];
	logic [PRESCALE_W-1:0] prescale_reg;
	logic flush_reg;
	logic exec;
	mie_pkg::mie_alu_t alu_op;
	logic [1:0] op_class;
	logic [3:0] sub;
	logic [6:0] faddr;
	logic [7:0] fval;
	logic [7:0] operand;
	logic [7:0] result;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic to_file;
	logic to_accum;
	logic upd_z;
	logic upd_cdc;
	logic skip;
	logic is_call;
	logic is_branch;
	logic is_kick;
	logic [12:0] jump_target;

	localparam int ADDR_LSB_W = mie_pkg::ADDR_W;
	assign op_class = i_instr[mie_pkg::CLASS_LSB +: 2];
	assign sub = i_instr[mie_pkg::SUB_LSB +: 4];
	assign faddr = i_instr[ADDR_LSB_W-1:0];
	assign fval = file_mem[faddr];
	assign jump_target = {i_pointer_high_latch[mie_pkg::LATCH_PAGE_LSB +: 2],
		i_instr[mie_pkg::JUMP_W-1:0]};
	// Execution happens on the last quarter so the word stays stable all cycle.
	assign exec = i_ce && (phase_reg == mie_pkg::MIE_PH4) && !flush_reg;
	assign o_instr_take = exec;
	assign o_flush = flush_reg;
	assign o_peek_data = file_mem[i_peek_addr];

	always_comb begin
		alu_op = mie_pkg::MIE_PASS_B;
		operand = fval;
		to_file = 1'b0;
		to_accum = 1'b0;
		upd_z = 1'b0;
		upd_cdc = 1'b0;
		skip = 1'b0;
		is_call = 1'b0;
		is_branch = 1'b0;
		is_kick = 1'b0;
		case (op_class)
			mie_pkg::CLASS_BYTE: begin
				to_file = i_instr[mie_pkg::DEST_BIT];
				to_accum = !i_instr[mie_pkg::DEST_BIT];
				upd_z = 1'b1;
				case (sub)
					4'h7: begin
						alu_op = mie_pkg::MIE_ADD;
						upd_cdc = 1'b1;
					end
					4'h5: alu_op = mie_pkg::MIE_AND;
					4'h4: alu_op = mie_pkg::MIE_OR;
					4'h1: alu_op = mie_pkg::MIE_CLR;
					4'h9: alu_op = mie_pkg::MIE_COM;
					4'h3: alu_op = mie_pkg::MIE_DEC;
					4'ha: alu_op = mie_pkg::MIE_INC;
					4'hb, 4'hf: begin
						alu_op = (sub == 4'hb) ? mie_pkg::MIE_DEC : mie_pkg::MIE_INC;
						upd_z = 1'b0;
						skip = alu_z;
					end
					4'h0: begin
						upd_z = 1'b0;
						alu_op = mie_pkg::MIE_PASS_A;
						to_accum = 1'b0;
						is_kick = !i_instr[mie_pkg::DEST_BIT] &&
							(i_instr[7:0] == mie_pkg::KICK_CODE);
					end
					default: begin
						upd_z = 1'b0;
						to_file = 1'b0;
						to_accum = 1'b0;
					end
				endcase
			end
			mie_pkg::CLASS_BIT: begin
				case (sub[3:2])
					2'h0: begin
						alu_op = mie_pkg::MIE_BCLR;
						to_file = 1'b1;
					end
					2'h1: begin
						alu_op = mie_pkg::MIE_BSET;
						to_file = 1'b1;
					end
					2'h2: skip = !fval[i_instr[mie_pkg::BIT_LSB +: 3]];
					default: skip = fval[i_instr[mie_pkg::BIT_LSB +: 3]];
				endcase
			end
			mie_pkg::CLASS_JUMP: begin
				is_call = !i_instr[mie_pkg::JUMP_W];
				is_branch = 1'b1;
			end
			default: begin
				operand = i_instr[7:0];
				to_accum = 1'b1;
				upd_z = 1'b1;
				case (sub)
					4'he, 4'hf: begin
						alu_op = mie_pkg::MIE_ADD;
						upd_cdc = 1'b1;
					end
					4'h9: alu_op = mie_pkg::MIE_AND;
					4'h8: alu_op = mie_pkg::MIE_OR;
					4'h0, 4'h1, 4'h2, 4'h3: begin
						alu_op = mie_pkg::MIE_PASS_B;
						upd_z = 1'b0;
					end
					default: begin
						to_accum = 1'b0;
						upd_z = 1'b0;
					end
				endcase
			end
		endcase
	end

	mie_alu u_alu (
		.i_op(alu_op),
		.i_a(o_accum),
		.i_b(operand),
		.i_bit(i_instr[mie_pkg::BIT_LSB +: 3]),
		.o_result(result),
		.o_carry(alu_c),
		.o_nibble(alu_dc),
		.o_zero(alu_z)
	);

	// Quarter-cycle sequencer.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			phase_reg <= mie_pkg::MIE_PH1;
		end else if (i_ce) begin
			case (phase_reg)
				mie_pkg::MIE_PH1: phase_reg <= mie_pkg::MIE_PH2;
				mie_pkg::MIE_PH2: phase_reg <= mie_pkg::MIE_PH3;
				mie_pkg::MIE_PH3: phase_reg <= mie_pkg::MIE_PH4;
				default: phase_reg <= mie_pkg::MIE_PH1;
			endcase
		end
	end

	// A taken skip or a jump turns the following cycle into an idle slot.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			flush_reg <= 1'b0;
		end else if (i_ce && phase_reg == mie_pkg::MIE_PH4) begin
			flush_reg <= exec && (skip || is_branch);
		end
	end

	// The pointer skips past the discarded word at once, so the idle slot holds it still.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_instruction_pointer <= mie_pkg::PTR_RESET;
		end else if (exec) begin
			if (is_branch) begin
				o_instruction_pointer <= jump_target;
			end else if (skip) begin
				o_instruction_pointer <= o_instruction_pointer + 13'h0002;
			end else begin
				o_instruction_pointer <= o_instruction_pointer + 13'h0001;
			end
		end
	end

	// Only one return slot is kept; deeper stacking lives outside this block.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_stack_head <= mie_pkg::PTR_RESET;
		end else if (exec && is_call) begin
			o_stack_head <= o_instruction_pointer + 13'h0001;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_accum <= mie_pkg::DATA_RESET;
		end else if (exec && to_accum) begin
			o_accum <= result;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 128; i++) begin
				file_mem[i] <= mie_pkg::DATA_RESET;
			end
		end else if (exec && to_file) begin
			file_mem[faddr] <= result;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_carry <= 1'b0;
			o_nibble_overflow_flag <= 1'b0;
			o_zero <= 1'b0;
		end else if (exec) begin
			if (upd_cdc) begin
				o_carry <= alu_c;
				o_nibble_overflow_flag <= alu_dc;
			end
			if (upd_z) begin
				o_zero <= alu_z;
			end
		end
	end

	// Prescaler ticks once per instruction cycle and carries into the counter.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			prescale_reg <= '0;
			o_watchdog_counter <= mie_pkg::DATA_RESET;
			o_expiry_flag <= mie_pkg::EXPIRY_RESET;
			o_sleep_entered_flag <= mie_pkg::SLEEP_RESET;
		end else if (exec && is_kick) begin
			prescale_reg <= '0;
			o_watchdog_counter <= mie_pkg::DATA_RESET;
			o_expiry_flag <= 1'b1;
			o_sleep_entered_flag <= 1'b1;
		end else if (i_ce && phase_reg == mie_pkg::MIE_PH4) begin
			prescale_reg <= prescale_reg + 1'b1;
			if (&prescale_reg) begin
				o_watchdog_counter <= o_watchdog_counter + 8'h01;
			end
		end
	end

	property p_cycle_wrap;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && phase_reg == mie_pkg::MIE_PH1 ##1 i_ce [*3] |=> phase_reg == mie_pkg::MIE_PH1;
	endproperty
	a_cycle_wrap: assert property (p_cycle_wrap) else $error("cycle not four clocks");

	property p_add_lit;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_LIT && sub[3:1] == 3'h7
		|=> {o_carry, o_accum} == {1'b0, $past(o_accum)} + {1'b0, $past(i_instr[7:0])};
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

	property p_clr_reg;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_BYTE && sub == 4'h1 && i_instr[7]
		|=> o_zero && file_mem[$past(faddr)] == 8'h00;
	endproperty
	a_clr_reg: assert property (p_clr_reg) else $error("clear register wrong");

	property p_clr_acc;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_BYTE && sub == 4'h1 && !i_instr[7]
		|=> o_zero && o_accum == 8'h00;
	endproperty
	a_clr_acc: assert property (p_clr_acc) else $error("clear accumulator wrong");

	property p_bit_flags;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_BIT
		|=> $stable(o_zero) && $stable(o_carry) && $stable(o_nibble_overflow_flag);
	endproperty
	a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags");

	property p_branch;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && is_branch |=> o_instruction_pointer == $past(jump_target) && flush_reg
		##[1:8] !flush_reg;
	endproperty
	a_branch: assert property (p_branch) else $error("branch wrong");

	property p_call;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && is_call |=> o_stack_head == $past(o_instruction_pointer) + 13'h0001;
	endproperty
	a_call: assert property (p_call) else $error("call push wrong");

	property p_kick;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && is_kick |=> o_watchdog_counter == 8'h00 && o_expiry_flag && o_sleep_entered_flag;
	endproperty
	a_kick: assert property (p_kick) else $error("watchdog kick wrong");

	property p_skip_idle;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		flush_reg && i_ce |=> $stable(o_accum) && $stable(o_instruction_pointer);
	endproperty
	a_skip_idle: assert property (p_skip_idle) else $error("idle slot changed state");

	property p_load_lit;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_LIT && sub[3:2] == 2'h0
		|=> o_accum == $past(i_instr[7:0]) && $stable(o_zero);
	endproperty
	a_load_lit: assert property (p_load_lit) else $error("load literal wrong");

	property p_add_reg;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_BYTE && sub == 4'h7
		&& !i_instr[mie_pkg::DEST_BIT]
		|=> {o_carry, o_accum} == {1'b0, $past(o_accum)} + {1'b0, $past(fval)};
	endproperty
	a_add_reg: assert property (p_add_reg) else $error("add register wrong");

	property p_bit_skip;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_BIT && sub[3:2] == 2'h3
		&& fval[i_instr[mie_pkg::BIT_LSB +: 3]]
		|=> flush_reg && o_instruction_pointer == $past(o_instruction_pointer) + 13'h0002;
	endproperty
	a_bit_skip: assert property (p_bit_skip) else $error("skip if one wrong");

	property p_store_acc;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		exec && op_class == mie_pkg::CLASS_BYTE && sub == 4'h0
		&& i_instr[mie_pkg::DEST_BIT]
		|=> file_mem[$past(faddr)] == $past(o_accum) && $stable(o_zero) && $stable(o_carry);
	endproperty
	a_store_acc: assert property (p_store_acc) else $error("store accumulator wrong");
endmodule // mie_core

//--- hdl/mie_pkg.sv
// Shared constants and types for the instruction execute block.
// Functional notes
// - Add literal to accumulator, update C, DC, Z.
// - Register select 0..127; target bit picks destination.
// - Add register and accumulator, update C, DC, Z.
// - AND/OR register with accumulator, only Z.
// - AND/OR literal into accumulator, only Z.
// - Bit clear/set touches one bit, no flags.
// - Skip-if-one discards next when bit set.
// - Skip-if-zero discards next when bit clear.
// - Clear register writes zero, sets Z.
// - Clear accumulator writes zero, sets Z.
// - Call pushes return, loads pointer, two cycles.
// - Branch loads pointer from literal and latch.
// - Watchdog kick clears counter, prescaler; sets flags.
// - Invert register, route result, only Z.
// - Decrement/increment register, route result, only Z.
// - Count-and-skip stores result, skips on zero.
// - Load literal into accumulator, no flags.
// - Store accumulator into register, no flags.
// - Instructions are single 14-bit words.
// - Instruction cycle lasts four clock periods.
package mie_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PTR_W = 13;
	localparam int LATCH_W = 5;
	localparam int WDT_W = 8;
	localparam int CYCLE_CLKS = 4;
	localparam int CLASS_LSB = 12;
	localparam int SUB_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam int BIT_LSB = 7;
	localparam int JUMP_W = 11;
	localparam int LATCH_PAGE_LSB = 3;
	localparam logic [1:0] CLASS_BYTE = 2'h0;
	localparam logic [1:0] CLASS_BIT = 2'h1;
	localparam logic [1:0] CLASS_JUMP = 2'h2;
	localparam logic [1:0] CLASS_LIT = 2'h3;
	localparam logic [7:0] KICK_CODE = 8'h64;
	localparam logic [12:0] PTR_RESET = 13'h0000;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic EXPIRY_RESET = 1'b1;
	localparam logic SLEEP_RESET = 1'b1;

	typedef enum logic [3:0] {
		MIE_PH1 = 4'h1,
		MIE_PH2 = 4'h2,
		MIE_PH3 = 4'h4,
		MIE_PH4 = 4'h8
	} mie_phase_t;

	typedef enum logic [3:0] {
		MIE_ADD, MIE_AND, MIE_OR, MIE_CLR, MIE_COM, MIE_DEC, MIE_INC,
		MIE_BCLR, MIE_BSET, MIE_PASS_A, MIE_PASS_B
	} mie_alu_t;
endpackage

//--- hdl/mie_alu.sv
// Combinational arithmetic and logic unit of the execute block.
`timescale 1ns/1ns
module mie_alu (
	input wire mie_pkg::mie_alu_t i_op, // Operation to perform
	input wire logic [7:0] i_a, // Accumulator operand
	input wire logic [7:0] i_b, // Register or literal operand
	input wire logic [2:0] i_bit, // Bit position for bit ops
	output logic [7:0] o_result, // Result byte
	output logic o_carry, // Carry out of bit 7
	output logic o_nibble, // Carry out of bit 3
	output logic o_zero // Result is zero
);
	logic [8:0] sum;
	logic [4:0] low_sum;

	always_comb begin
		sum = {1'b0, i_a} + {1'b0, i_b};
		low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
		o_carry = sum[8];
		o_nibble = low_sum[4];
		case (i_op)
			mie_pkg::MIE_ADD: o_result = sum[7:0];
			mie_pkg::MIE_AND: o_result = i_a & i_b;
			mie_pkg::MIE_OR: o_result = i_a | i_b;
			mie_pkg::MIE_CLR: o_result = mie_pkg::DATA_RESET;
			mie_pkg::MIE_COM: o_result = ~i_b;
			mie_pkg::MIE_DEC: o_result = i_b - 8'h01;
			mie_pkg::MIE_INC: o_result = i_b + 8'h01;
			mie_pkg::MIE_BCLR: o_result = i_b & ~(8'h01 << i_bit);
			mie_pkg::MIE_BSET: o_result = i_b | (8'h01 << i_bit);
			mie_pkg::MIE_PASS_A: o_result = i_a;
			default: o_result = i_b;
		endcase
		o_zero = (o_result == 8'h00);
	end
endmodule // mie_alu

//--- tb/testbench.sv
// Self-checking testbench for the instruction execute core.
`timescale 1ns/1ns
module testbench;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_ce = 1'b1;
	logic [13:0] i_instr = 14'h0000;
	logic [4:0] i_pointer_high_latch = 5'h00;
	logic [6:0] i_peek_addr = 7'h00;
	logic o_instr_take;
	logic [7:0] o_peek_data;
	logic [12:0] o_instruction_pointer;
	logic [12:0] o_stack_head;
	logic [7:0] o_accum;
	logic o_carry;
	logic o_nibble_overflow_flag;
	logic o_zero;
	logic o_expiry_flag;
	logic o_sleep_entered_flag;
	logic [7:0] o_watchdog_counter;
	logic o_flush;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;

	mie_core #(.PRESCALE_W(7)) u_mie_core (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_instr(i_instr),
		.i_pointer_high_latch(i_pointer_high_latch),
		.i_peek_addr(i_peek_addr),
		.o_instr_take(o_instr_take),
		.o_peek_data(o_peek_data),
		.o_instruction_pointer(o_instruction_pointer),
		.o_stack_head(o_stack_head),
		.o_accum(o_accum),
		.o_carry(o_carry),
		.o_nibble_overflow_flag(o_nibble_overflow_flag),
		.o_zero(o_zero),
		.o_expiry_flag(o_expiry_flag),
		.o_sleep_entered_flag(o_sleep_entered_flag),
		.o_watchdog_counter(o_watchdog_counter),
		.o_flush(o_flush)
	);

	always #2 i_sys_clk = ~i_sys_clk;

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The whole run needs under a thousand clocks; this ceiling only catches a hang.
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [13:0] bo(input logic [3:0] s, input logic d, input logic [6:0] f);
		return {2'b00, s, d, f};
	endfunction

	function automatic logic [13:0] bt(input logic [1:0] o, input logic [2:0] b,
			input logic [6:0] f);
		return {2'b01, o, b, f};
	endfunction

	// Holds the word until the core takes it, then returns where results have settled.
	task automatic run(input logic [13:0] w, input logic [6:0] pa);
		int n;
		@(posedge i_sys_clk);
		i_instr <= w;
		i_peek_addr <= pa;
		n = 0;
		@(negedge i_sys_clk);
		while (o_instr_take !== 1'b1 && n < 20) begin
			@(negedge i_sys_clk);
			n++;
		end
		if (n >= 20) chk("take", 13'h0000, 13'h0001);
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask

	task automatic ac(input logic [7:0] e);
		chk("accum", 13'(o_accum), 13'(e));
	endtask

	task automatic pk(input logic [7:0] e);
		chk("file", 13'(o_peek_data), 13'(e));
	endtask

	task automatic fl(input logic [2:0] e);
		chk("flags", 13'({o_carry, o_nibble_overflow_flag, o_zero}), 13'(e));
	endtask

	task automatic skp(input logic [13:0] w, input logic [6:0] pa, input logic [12:0] d);
		logic [12:0] p;
		p = o_instruction_pointer;
		run(w, pa);
		chk("pointer", o_instruction_pointer, p + d);
		chk("flush", 13'(o_flush), 13'(d == 13'h0002));
	endtask

	task automatic t_literal();
		run(14'h3010, 7'h00);
		ac(8'h10);
		fl(3'b000);
		run(14'h3e05, 7'h00);
		ac(8'h15);
		fl(3'b000);
		run(14'h3efb, 7'h00);
		ac(8'h10);
		fl(3'b110);
		run(14'h390f, 7'h00);
		ac(8'h00);
		fl(3'b111);
		run(14'h38a0, 7'h00);
		ac(8'ha0);
		fl(3'b110);
		chk("pointer", o_instruction_pointer, 13'h0005);
	endtask

	task automatic t_regs();
		run(14'h3080, 7'h00);
		run(bo(4'h0, 1'b1, 7'h7f), 7'h7f);
		pk(8'h80);
		fl(3'b110);
		run(bo(4'h7, 1'b0, 7'h7f), 7'h7f);
		ac(8'h00);
		pk(8'h80);
		fl(3'b101);
		run(bo(4'h9, 1'b1, 7'h7f), 7'h7f);
		pk(8'h7f);
		fl(3'b100);
		run(bo(4'ha, 1'b0, 7'h7f), 7'h7f);
		ac(8'h80);
		pk(8'h7f);
		run(bo(4'h3, 1'b1, 7'h7f), 7'h7f);
		pk(8'h7e);
		run(bo(4'h5, 1'b1, 7'h7f), 7'h7f);
		pk(8'h00);
		fl(3'b101);
		run(bo(4'h4, 1'b0, 7'h7f), 7'h7f);
		ac(8'h80);
		fl(3'b100);
		run(bo(4'h7, 1'b1, 7'h7f), 7'h7f);
		pk(8'h80);
		fl(3'b000);
		run(bo(4'h1, 1'b0, 7'h03), 7'h7f);
		ac(8'h00);
		fl(3'b001);
		run(14'h3001, 7'h7f);
		run(bo(4'h4, 1'b1, 7'h7f), 7'h7f);
		pk(8'h81);
		fl(3'b000);
		run(bo(4'h1, 1'b1, 7'h7f), 7'h7f);
		pk(8'h00);
		fl(3'b001);
	endtask

	task automatic t_bits();
		run(14'h3005, 7'h10);
		run(bo(4'h0, 1'b1, 7'h10), 7'h10);
		run(bt(2'h1, 3'h7, 7'h10), 7'h10);
		pk(8'h85);
		run(bt(2'h0, 3'h0, 7'h10), 7'h10);
		pk(8'h84);
		fl(3'b001);
		skp(bt(2'h3, 3'h7, 7'h10), 7'h10, 13'h0002);
		skp(bt(2'h2, 3'h7, 7'h10), 7'h10, 13'h0001);
		skp(bt(2'h2, 3'h0, 7'h10), 7'h10, 13'h0002);
		skp(bt(2'h3, 3'h0, 7'h10), 7'h10, 13'h0001);
		fl(3'b001);
	endtask

	task automatic t_count();
		run(14'h3001, 7'h20);
		run(bo(4'h0, 1'b1, 7'h20), 7'h20);
		skp(bo(4'hb, 1'b1, 7'h20), 7'h20, 13'h0002);
		pk(8'h00);
		skp(bo(4'hf, 1'b0, 7'h20), 7'h20, 13'h0001);
		ac(8'h01);
		pk(8'h00);
		fl(3'b001);
	endtask

	task automatic t_jump();
		logic [12:0] s;
		@(posedge i_sys_clk);
		i_pointer_high_latch <= 5'h18;
		s = o_stack_head;
		run(14'h2ffe, 7'h00);
		chk("pointer", o_instruction_pointer, 13'h1ffe);
		chk("stack", o_stack_head, s);
		chk("flush", 13'(o_flush), 13'h0001);
		@(posedge i_sys_clk);
		i_pointer_high_latch <= 5'h08;
		run(14'h2123, 7'h00);
		chk("pointer", o_instruction_pointer, 13'h0923);
		chk("stack", o_stack_head, 13'h1fff);
		chk("flush", 13'(o_flush), 13'h0001);
	endtask

	task automatic t_wdog();
		logic [12:0] p;
		run(14'h0064, 7'h00);
		chk("watchdog", 13'(o_watchdog_counter), 13'h0000);
		chk("expiry", 13'(o_expiry_flag), 13'h0001);
		chk("sleep", 13'(o_sleep_entered_flag), 13'h0001);
		repeat (127) run(14'h0000, 7'h00);
		chk("watchdog", 13'(o_watchdog_counter), 13'h0000);
		run(14'h0000, 7'h00);
		chk("watchdog", 13'(o_watchdog_counter), 13'h0001);
		run(14'h0064, 7'h00);
		chk("watchdog", 13'(o_watchdog_counter), 13'h0000);
		@(posedge i_sys_clk);
		i_ce <= 1'b0;
		p = o_instruction_pointer;
		repeat (12) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk("frozen", o_instruction_pointer, p);
		@(posedge i_sys_clk);
		i_ce <= 1'b1;
		run(14'h0000, 7'h00);
		chk("pointer", o_instruction_pointer, p + 13'h0001);
	endtask

	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		@(negedge i_sys_clk);
		chk("pointer", o_instruction_pointer, 13'h0000);
		chk("expiry", 13'(o_expiry_flag), 13'h0001);
		t_literal();
		t_regs();
		t_bits();
		t_count();
		t_jump();
		t_wdog();
		finish_test();
	end
endmodule // testbench
